/* nti_pkg.sv */
/*
  Shared constants and state types for the ID translation and IPC block.
  Assumes one clock domain and a 32-bit AXI4-Lite register bus.
*/
package nti_pkg;
  // ==========================================================
  // Sizes
  localparam int NFN  = 4;
  localparam int NMSG = 4;
  localparam int NMAP = 64;
  localparam int NDB  = 32;
  localparam int MAPW = 20;

  // ==========================================================
  // Per-function register offsets (4KB window each)
  localparam logic [11:0] OFF_ID     = 12'h000;
  localparam logic [11:0] OFF_CMD    = 12'h004;
  localparam logic [11:0] OFF_CLASS  = 12'h008;
  localparam logic [11:0] OFF_HDR    = 12'h00C;
  localparam logic [11:0] OFF_BDF    = 12'h080;
  localparam logic [11:0] OFF_CAPID  = 12'h084;
  localparam logic [7:0]  OFF_OMSG   = 8'h10;
  localparam logic [7:0]  OFF_IMSG   = 8'h11;
  localparam logic [7:0]  OFF_MMAP   = 8'h12;
  localparam logic [11:0] OFF_MSTAT  = 12'h130;
  localparam logic [11:0] OFF_MMASK  = 12'h134;
  localparam logic [11:0] OFF_ODB    = 12'h140;
  localparam logic [11:0] OFF_IDB    = 12'h144;
  localparam logic [11:0] OFF_DBMASK = 12'h148;
  localparam logic [11:0] OFF_PTADDR = 12'h150;
  localparam logic [11:0] OFF_PTDATA = 12'h154;
  localparam logic [11:0] OFF_PTCTRL = 12'h158;
  localparam logic [4:0]  OFF_DBRT   = 5'h04;
  localparam logic [3:0]  OFF_MAP    = 4'h4;

  // ==========================================================
  // Fixed header values; ID value is arbitrary
  localparam logic [31:0] ID_VALUE    = 32'h5A5A_0001;
  localparam logic [31:0] CLASS_VALUE = 32'h0680_0000;
  localparam logic [31:0] HDR_VALUE   = 32'h0000_0000;

  // ==========================================================
  // Field positions and codes
  localparam int          MAP_V      = 0;
  localparam int          MAP_PART   = 17;
  localparam logic [1:0]  XL_DEV43   = 2'b10;
  localparam logic [1:0]  CPL_RANGE  = 2'b10;
  localparam int          PT_GO      = 0;
  localparam int          PT_WR      = 1;
  localparam logic [1:0]  AXI_OKAY   = 2'b00;
  localparam logic [1:0]  AXI_SLVERR = 2'b10;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    PT_IDLE = 3'b001,
    PT_SEND = 3'b010,
    PT_WAIT = 3'b100
  } nti_pt_type;

  typedef enum logic [4:0] {
    RG_NONE, RG_ID, RG_CMD, RG_CLASS, RG_HDR, RG_BDF, RG_CAPID,
    RG_OMSG, RG_IMSG, RG_MMAP, RG_MSTAT, RG_MMASK, RG_ODB, RG_IDB,
    RG_DBMASK, RG_PTADDR, RG_PTDATA, RG_PTCTRL, RG_DBRT, RG_MAP
  } nti_reg_type;

  typedef struct packed {
    logic        reqDone;
    logic        reqFwd;
    logic [15:0] reqId;
    logic        cplDone;
    logic        cplFwd;
    logic [15:0] cplReqId;
    logic [15:0] cplCmplId;
    logic [2:0]  cplPart;
  } nti_xl_type;

  typedef struct packed {
    logic                             awHave;
    logic [13:0]                      awAddr;
    logic                             wHave;
    logic [31:0]                      wData;
    logic [3:0]                       wStrb;
    logic                             bValid;
    logic [1:0]                       bResp;
    logic                             rValid;
    logic [31:0]                      rData;
    logic [1:0]                       rResp;
    logic                             cfgDone;
    logic [31:0]                      cfgData;
    logic [NMAP-1:0][MAPW-1:0]        map;
    logic [NFN-1:0][15:0]             bdf;
    logic [NFN-1:0][15:0]             cmd;
    logic [NFN-1:0][NMSG-1:0][31:0]   outMsg;
    logic [NFN-1:0][NMSG-1:0][31:0]   inMsg;
    logic [NFN-1:0][NMSG-1:0][3:0]    msgMap;
    logic [NFN-1:0][NMSG-1:0]         inFull;
    logic [NFN-1:0][NMSG-1:0]         outFail;
    logic [NFN-1:0][7:0]              msgMask;
    logic [NFN-1:0][NDB-1:0]          inDb;
    logic [NFN-1:0][NDB-1:0]          dbMask;
    logic [NFN-1:0][NDB-1:0][3:0]     dbRoute;
    logic [NFN-1:0][31:0]             ptAddr;
    logic [NFN-1:0][31:0]             ptData;
    logic [NFN-1:0]                   ptWrite;
    nti_pt_type [NFN-1:0]             pt;
    logic [NFN-1:0]                   irq;
  } nti_state_type;
endpackage

/* nti_id_xlate.sv */
/*
  Requester and completer ID translation against the mapping table.
  Assumes table and function BDFs are held stable by the register file.
*/
`timescale 1ns/1ns
module nti_id_xlate
  import nti_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      reset,
  input  wire logic [NMAP-1:0][MAPW-1:0] mapTable,
  input  wire logic [NFN-1:0][15:0]      funcBdf,
  input  wire logic                      reqValid,
  input  wire logic [2:0]                reqPart,
  input  wire logic [15:0]               reqRequesterId,
  input  wire logic [1:0]                reqEgressFunc,
  output logic                           reqDone,
  output logic                           reqForward,
  output logic [15:0]                    reqNewId,
  input  wire logic                      cplValid,
  input  wire logic [15:0]               cplRequesterId,
  output logic                           cplDone,
  output logic                           cplForward,
  output logic [15:0]                    cplNewRequesterId,
  output logic [15:0]                    cplNewCompleterId,
  output logic [2:0]                     cplPart
);
  nti_xl_type          st;
  nti_xl_type          next_st;
  logic                hit;
  logic [5:0]          idx;
  logic [MAPW-1:0]     ent;

  // ==========================================================
  // Lookup and rewrite, results registered
  always_comb begin
    next_st = st;
    hit = 1'b0;
    idx = 6'h00;
    // Partition plus full ID against valid entries [RL2]
    for (int i = NMAP - 1; i >= 0; i--) begin
      if (mapTable[i][MAP_V] && mapTable[i][19:17] == reqPart &&
          mapTable[i][16:1] == reqRequesterId) begin
        hit = 1'b1;
        idx = 6'(i);
      end
    end
    next_st.reqDone = reqValid;
    next_st.reqFwd  = reqValid & hit; // [RL27]
    // Egress bus, device 1_0xxx, entry number [RL3] [RL22]
    next_st.reqId = {funcBdf[reqEgressFunc][15:8], XL_DEV43, idx};
    // Completion: range check then low six bits index [RL23]
    ent = mapTable[cplRequesterId[5:0]];
    next_st.cplDone   = cplValid;
    next_st.cplFwd    = cplValid && cplRequesterId[7:6] == CPL_RANGE &&
                        ent[MAP_V] && ent[19:17] < 3'(NFN);
    next_st.cplReqId  = ent[16:1]; // [RL4]
    next_st.cplCmplId = funcBdf[ent[MAP_PART +: 2]]; // [RL4]
    next_st.cplPart   = ent[19:17]; // [RL5]
  end

  // State register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reqDone           = st.reqDone;
  assign reqForward        = st.reqFwd;
  assign reqNewId          = st.reqId;
  assign cplDone           = st.cplDone;
  assign cplForward        = st.cplFwd;
  assign cplNewRequesterId = st.cplReqId;
  assign cplNewCompleterId = st.cplCmplId;
  assign cplPart           = st.cplPart;
endmodule

/* nti_bridge.sv */
/*
  NT bridge register file, messages, doorbells, punch-through, ID translation.
  Assumes AXI4-Lite master, config requests from the link side, one clock.
*/
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns

// What this block does
// RL1 - Capture register config read returns reader's ID.
// RL2 - Requests match partition and requester ID in valid entries.
// RL3 - Match: egress bus, device/function carry entry number.
// RL4 - Completions take entry BDF and emitter BDF.
// RL5 - Completion goes to entry's partition.
// RL6 - Each crossing translates independently.
// RL7 - 32-bit messages cross partitions with interrupts.
// RL8 - Four outbound, four inbound message registers per function.
// RL9 - Each outbound register maps to one inbound register.
// RL10 - Inbound message interrupts unless masked.
// RL11 - Reading inbound message empties it.
// RL12 - Full target fails delivery and interrupts sender.
// RL13 - 32-bit outbound and inbound doorbells per function.
// RL14 - Each doorbell bit routes to a partition set.
// RL15 - Inbound doorbell interrupts unless masked.
// RL16 - Doorbells are unqueued edges.
// RL17 - Software sets up table before traffic.
// RL18 - 4KB type 0 config space per function.
// RL19 - Config space also mapped through BAR0.
// RL20 - Own root complex configures each function.
// RL21 - Punch-through config leaves on own link.
// RL22 - Translated device bits 4:3 are 10.
// RL23 - Completion lookup only when ID bits 7:6 are 10.
// RL24 - One shared 64-entry table.
// RL25 - Entry fields: valid, func, dev, bus, partition.
// RL26 - Inbound doorbell bits clear on write one.
// RL27 - Unmatched requests are not forwarded.
module nti_bridge
  import nti_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   reset,
  input  wire logic [13:0]            awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [13:0]            araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  input  wire logic                   cfgValid,
  input  wire logic                   cfgWrite,
  input  wire logic [1:0]             cfgFunc,
  input  wire logic [11:0]            cfgOffset,
  input  wire logic [31:0]            cfgWrData,
  input  wire logic [15:0]            cfgRequesterId,
  output logic                        cfgDone,
  output logic [31:0]                 cfgRdData,
  input  wire logic                   reqValid,
  input  wire logic [2:0]             reqPart,
  input  wire logic [15:0]            reqRequesterId,
  input  wire logic [1:0]             reqEgressFunc,
  output logic                        reqDone,
  output logic                        reqForward,
  output logic [15:0]                 reqNewId,
  input  wire logic                   cplValid,
  input  wire logic [15:0]            cplRequesterId,
  output logic                        cplDone,
  output logic                        cplForward,
  output logic [15:0]                 cplNewRequesterId,
  output logic [15:0]                 cplNewCompleterId,
  output logic [2:0]                  cplPart,
  output logic [NFN-1:0]              ptReqValid,
  output logic [NFN-1:0]              ptReqWrite,
  output logic [NFN-1:0][31:0]        ptReqAddr,
  output logic [NFN-1:0][31:0]        ptReqData,
  input  wire logic [NFN-1:0]         ptReqReady,
  input  wire logic [NFN-1:0]         ptCplValid,
  input  wire logic [NFN-1:0][31:0]   ptCplData,
  output logic [NFN-1:0]              ntIrq
);
  nti_state_type           st;
  nti_state_type           next_st;
  logic                    doWr;
  logic                    accEn;
  logic                    accWr;
  logic [1:0]              accFn;
  logic [11:0]             accOff;
  logic [31:0]             accMask;
  logic [31:0]             accData;
  logic [31:0]             rdVal;
  logic [31:0]             merged;
  logic [31:0]             w1;
  nti_reg_type             kind;
  logic [3:0]              tgt;
  logic [NFN-1:0][NDB-1:0] dbSet;

  // ==========================================================
  // Register decode, shared by reads and writes
  function automatic nti_reg_type reg_decode(input logic [11:0] off);
    nti_reg_type k;
    k = RG_NONE;
    if (off[11:8] == OFF_MAP) begin
      k = RG_MAP;
    end else if (off[11:7] == OFF_DBRT) begin
      k = RG_DBRT;
    end else if (off[11:4] == OFF_OMSG) begin
      k = RG_OMSG;
    end else if (off[11:4] == OFF_IMSG) begin
      k = RG_IMSG;
    end else if (off[11:4] == OFF_MMAP) begin
      k = RG_MMAP;
    end else begin
      case ({off[11:2], 2'b00})
        OFF_ID:     k = RG_ID;
        OFF_CMD:    k = RG_CMD;
        OFF_CLASS:  k = RG_CLASS;
        OFF_HDR:    k = RG_HDR;
        OFF_BDF:    k = RG_BDF;
        OFF_CAPID:  k = RG_CAPID;
        OFF_MSTAT:  k = RG_MSTAT;
        OFF_MMASK:  k = RG_MMASK;
        OFF_ODB:    k = RG_ODB;
        OFF_IDB:    k = RG_IDB;
        OFF_DBMASK: k = RG_DBMASK;
        OFF_PTADDR: k = RG_PTADDR;
        OFF_PTDATA: k = RG_PTDATA;
        OFF_PTCTRL: k = RG_PTCTRL;
        default:    k = RG_NONE;
      endcase
    end
    return k;
  endfunction

  // ==========================================================
  // Access arbitration: link config, then AXI write, then read
  assign doWr    = st.awHave & st.wHave & ~st.bValid & ~cfgValid;
  assign awready = ~st.awHave & ~st.bValid;
  assign wready  = ~st.wHave & ~st.bValid;
  assign arready = ~st.rValid & ~cfgValid & ~doWr;
  assign accEn   = cfgValid | doWr | (arvalid & arready);
  assign accWr   = cfgValid ? cfgWrite : doWr;
  assign accFn   = cfgValid ? cfgFunc : (doWr ? st.awAddr[13:12] : araddr[13:12]);
  assign accOff  = cfgValid ? cfgOffset : (doWr ? st.awAddr[11:0] : araddr[11:0]);
  assign accData = cfgValid ? cfgWrData : st.wData;
  assign kind    = reg_decode(accOff);
  assign tgt     = st.msgMap[accFn][accOff[3:2]];

  // Byte lanes; link config writes are whole words
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      accMask[8*b +: 8] = (cfgValid | st.wStrb[b]) ? 8'hFF : 8'h00;
    end
  end

  // Read value of the addressed register, no side effects [RL18] [RL19]
  always_comb begin
    case (kind)
      RG_ID:     rdVal = ID_VALUE;
      RG_CMD:    rdVal = {16'h0000, st.cmd[accFn]};
      RG_CLASS:  rdVal = CLASS_VALUE;
      RG_HDR:    rdVal = HDR_VALUE;
      RG_BDF:    rdVal = {16'h0000, st.bdf[accFn]};
      RG_CAPID:  rdVal = {16'h0000, cfgValid ? cfgRequesterId : 16'h0000}; // [RL1]
      RG_OMSG:   rdVal = st.outMsg[accFn][accOff[3:2]];
      RG_IMSG:   rdVal = st.inMsg[accFn][accOff[3:2]]; // [RL8]
      RG_MMAP:   rdVal = {28'h0000000, tgt};
      RG_MSTAT:  rdVal = {24'h000000, st.outFail[accFn], st.inFull[accFn]};
      RG_MMASK:  rdVal = {24'h000000, st.msgMask[accFn]};
      RG_ODB:    rdVal = 32'h0000_0000;
      RG_IDB:    rdVal = st.inDb[accFn];
      RG_DBMASK: rdVal = st.dbMask[accFn];
      RG_PTADDR: rdVal = st.ptAddr[accFn];
      RG_PTDATA: rdVal = st.ptData[accFn];
      RG_PTCTRL: rdVal = {30'h00000000, st.ptWrite[accFn], st.pt[accFn] != PT_IDLE};
      RG_DBRT:   rdVal = {28'h0000000, st.dbRoute[accFn][accOff[6:2]]};
      RG_MAP:    rdVal = {12'h000, st.map[accOff[7:2]]}; // [RL24]
      default:   rdVal = 32'h0000_0000;
    endcase
  end

  assign merged = (rdVal & ~accMask) | (accData & accMask);
  assign w1     = accData & accMask;

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_st = st;
    dbSet   = '0;
    next_st.cfgDone = cfgValid;
    // AXI channel capture and release
    if (awvalid && awready) begin
      next_st.awHave = 1'b1;
      next_st.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      next_st.wHave = 1'b1;
      next_st.wData = wdata;
      next_st.wStrb = wstrb;
    end
    if (st.bValid && bready) begin
      next_st.bValid = 1'b0;
    end
    if (st.rValid && rready) begin
      next_st.rValid = 1'b0;
    end
    // Answers
    if (cfgValid) begin
      next_st.cfgData = rdVal;
    end else if (doWr) begin
      next_st.awHave = 1'b0;
      next_st.wHave  = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp  = (kind == RG_NONE) ? AXI_SLVERR : AXI_OKAY;
    end else if (accEn) begin
      next_st.rValid = 1'b1;
      next_st.rData  = rdVal;
      next_st.rResp  = (kind == RG_NONE) ? AXI_SLVERR : AXI_OKAY;
    end
    // Read side effect: inbound message empties [RL11]
    if (accEn && !accWr && kind == RG_IMSG) begin
      next_st.inFull[accFn][accOff[3:2]] = 1'b0;
    end
    // Register writes
    if (accEn && accWr) begin
      case (kind)
        RG_CMD:    next_st.cmd[accFn] = merged[15:0];
        RG_BDF:    next_st.bdf[accFn] = merged[15:0];
        RG_MMAP:   next_st.msgMap[accFn][accOff[3:2]] = merged[3:0]; // [RL9]
        RG_MMASK:  next_st.msgMask[accFn] = merged[7:0];
        RG_DBMASK: next_st.dbMask[accFn] = merged;
        RG_PTADDR: next_st.ptAddr[accFn] = merged;
        RG_PTDATA: next_st.ptData[accFn] = merged;
        RG_DBRT:   next_st.dbRoute[accFn][accOff[6:2]] = merged[3:0]; // [RL14]
        RG_MAP:    next_st.map[accOff[7:2]] = merged[MAPW-1:0]; // [RL25]
        RG_MSTAT:  next_st.outFail[accFn] = st.outFail[accFn] & ~w1[7:4];
        RG_IDB:    next_st.inDb[accFn] = st.inDb[accFn] & ~w1; // [RL26]
        RG_OMSG: begin
          next_st.outMsg[accFn][accOff[3:2]] = merged;
          // Deliver only to an empty slot of another function [RL7] [RL12]
          if (tgt[3:2] != accFn && !st.inFull[tgt[3:2]][tgt[1:0]]) begin
            next_st.inMsg[tgt[3:2]][tgt[1:0]]  = merged;
            next_st.inFull[tgt[3:2]][tgt[1:0]] = 1'b1;
          end else begin
            next_st.outFail[accFn][accOff[3:2]] = 1'b1; // [RL12]
          end
        end
        RG_ODB: begin
          // Fan each rung bit out to its receiving set [RL13] [RL14]
          for (int n = 0; n < NDB; n++) begin
            for (int g = 0; g < NFN; g++) begin
              dbSet[g][n] = w1[n] & st.dbRoute[accFn][n][g];
            end
          end
        end
        RG_PTCTRL: begin
          // Start punch-through when idle [RL21]
          if (w1[PT_GO] && st.pt[accFn] == PT_IDLE) begin
            next_st.ptWrite[accFn] = merged[PT_WR];
            next_st.pt[accFn]      = PT_SEND;
          end
        end
        default: begin
        end
      endcase
    end
    // Doorbell set wins over the clear; a set bit absorbs repeats [RL16]
    for (int g = 0; g < NFN; g++) begin
      next_st.inDb[g] = next_st.inDb[g] | dbSet[g];
    end
    // Punch-through sequencing on each function's own link [RL21]
    for (int f = 0; f < NFN; f++) begin
      case (st.pt[f])
        PT_IDLE: begin
        end
        PT_SEND: begin
          if (ptReqReady[f]) begin
            next_st.pt[f] = PT_WAIT;
          end
        end
        PT_WAIT: begin
          if (ptCplValid[f]) begin
            next_st.ptData[f] = ptCplData[f];
            next_st.pt[f]     = PT_IDLE;
          end
        end
        default: next_st.pt[f] = PT_IDLE;
      endcase
    end
    // Per-function interrupt from unmasked events [RL10] [RL15]
    for (int f = 0; f < NFN; f++) begin
      next_st.irq[f] = |(next_st.inFull[f] & ~next_st.msgMask[f][3:0]) |
                       |(next_st.outFail[f] & ~next_st.msgMask[f][7:4]) |
                       |(next_st.inDb[f] & ~next_st.dbMask[f]);
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st    <= '0;
      st.pt <= {NFN{PT_IDLE}};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign bvalid    = st.bValid;
  assign bresp     = st.bResp;
  assign rvalid    = st.rValid;
  assign rdata     = st.rData;
  assign rresp     = st.rResp;
  assign cfgDone   = st.cfgDone;
  assign cfgRdData = st.cfgData;
  assign ntIrq     = st.irq;

  // Punch-through request lines per function
  genvar gf;
  generate
    for (gf = 0; gf < NFN; gf++) begin : g_pt
      assign ptReqValid[gf] = (st.pt[gf] == PT_SEND);
      assign ptReqWrite[gf] = st.ptWrite[gf];
      assign ptReqAddr[gf]  = st.ptAddr[gf];
      assign ptReqData[gf]  = st.ptData[gf];
    end
  endgenerate

  // ==========================================================
  // ID translation; every crossing uses this table and the function BDFs [RL6]
  nti_id_xlate u_xlate (
    .mclk              (mclk),
    .reset             (reset),
    .mapTable          (st.map),
    .funcBdf           (st.bdf),
    .reqValid          (reqValid),
    .reqPart           (reqPart),
    .reqRequesterId    (reqRequesterId),
    .reqEgressFunc     (reqEgressFunc),
    .reqDone           (reqDone),
    .reqForward        (reqForward),
    .reqNewId          (reqNewId),
    .cplValid          (cplValid),
    .cplRequesterId    (cplRequesterId),
    .cplDone           (cplDone),
    .cplForward        (cplForward),
    .cplNewRequesterId (cplNewRequesterId),
    .cplNewCompleterId (cplNewCompleterId),
    .cplPart           (cplPart)
  );
endmodule

/* nti_bridge_assertions.sv */
/* Checker on the nti_bridge ports.
   Assumes one clock and attachment by the bind below. */
`timescale 1ns/1ns
module nti_bridge_assertions
  import nti_pkg::*;
(
  input wire logic           mclk, reset, cfgValid, cfgWrite, cfgDone,
  input wire logic           reqValid, reqDone, reqForward, cplValid, cplDone,
  input wire logic           cplForward, bvalid, bready, rvalid, rready,
  input wire logic [11:0]    cfgOffset,
  input wire logic [15:0]    cfgRequesterId, reqNewId, cplRequesterId,
  input wire logic [31:0]    cfgRdData,
  input wire logic [NFN-1:0] ptReqValid, ptReqReady
);
  // ========
  // Timing and value relations
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  property p_cfg; cfgValid |=> cfgDone; endproperty
  property p_cap; cfgValid && !cfgWrite && cfgOffset == OFF_CAPID
    |=> cfgRdData == {16'h0000, $past(cfgRequesterId)}; endproperty
  property p_req; reqValid |=> reqDone; endproperty
  property p_xid; reqDone && reqForward |-> reqNewId[7:6] == XL_DEV43; endproperty
  property p_cpl; cplValid && cplRequesterId[7:6] != CPL_RANGE
    |=> cplDone && !cplForward; endproperty
  property p_bend; bvalid && bready |=> !bvalid; endproperty
  property p_rend; rvalid && rready |=> !rvalid; endproperty
  property p_pt; ptReqValid[0] && !ptReqReady[0] |=> ptReqValid[0]; endproperty
  a_cfg: assert property (p_cfg) else $error("no config answer");
  a_cap: assert property (p_cap) else $error("bad captured id");
  a_req: assert property (p_req) else $error("no request answer");
  a_xid: assert property (p_xid) else $error("bad device bits");
  a_cpl: assert property (p_cpl) else $error("out of range forwarded");
  a_bend: assert property (p_bend) else $error("write answer repeated");
  a_rend: assert property (p_rend) else $error("read answer repeated");
  a_pt: assert property (p_pt) else $error("punch request dropped");
  c_req: cover property (reqDone && reqForward);
  c_cpl: cover property (cplDone && cplForward);
  c_pt: cover property (ptReqValid[0] && ptReqReady[0]);
endmodule
bind nti_bridge nti_bridge_assertions u_chk (.*);

/* nti_pt_partner.sv */
/* Far side of the punch-through links, one per NT function.
   Assumes requests are held until ready. */
`timescale 1ns/1ns
module nti_pt_partner
  import nti_pkg::*;
#(
  parameter int          DLY      = 3,
  parameter logic [31:0] CPL_DATA = 32'h0000_0001
)(
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire logic [NFN-1:0]       ptReqValid,
  input  wire logic [NFN-1:0][31:0] ptReqAddr,
  output logic      [NFN-1:0]       ptReqReady,
  output logic      [NFN-1:0]       ptCplValid,
  output logic      [NFN-1:0][31:0] ptCplData
);
  int cnt [NFN];
  // Slow ready, completion after take, data churns when idle
  always_ff @(posedge mclk or posedge reset) begin
    for (int f = 0; f < NFN; f++) begin
      if (reset) begin
        cnt[f] <= 0;
        ptReqReady[f] <= 1'b0;
        ptCplValid[f] <= 1'b0;
        ptCplData[f] <= '0;
      end else begin
        cnt[f] <= (ptReqValid[f] && !ptReqReady[f]) ? cnt[f] + 1 : 0;
        ptReqReady[f] <= ptReqValid[f] && !ptReqReady[f] && cnt[f] == DLY - 1;
        ptCplValid[f] <= ptReqValid[f] && ptReqReady[f];
        ptCplData[f] <= ptReqValid[f] && ptReqReady[f] ? CPL_DATA ^ ptReqAddr[f] : ~ptCplData[f];
      end
    end
  end
endmodule

/* ntb_id_translation_and_ipc_bench.sv */
/* Bench for nti_bridge over AXI4-Lite, config and translation ports.
   Assumes nti_pt_partner on the punch-through links. */
`timescale 1ns/1ns
module ntb_id_translation_and_ipc_bench
  import nti_pkg::*;
;
  localparam logic [31:0] PT_REPLY = 32'h00C0_FFEE;
  logic mclk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic cfgValid = 0, cfgWrite = 0, reqValid = 0, cplValid = 0;
  logic [13:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, cfgWrData = 0, rdata, cfgRdData, v;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] cfgFunc = 0, reqEgressFunc = 0, bresp, rresp;
  logic [11:0] cfgOffset = 0;
  logic [15:0] cfgRequesterId = 0, reqRequesterId = 0, cplRequesterId = 0;
  logic [15:0] reqNewId, cplNewRequesterId, cplNewCompleterId;
  logic [2:0] reqPart = 0, cplPart;
  logic awready, wready, bvalid, arready, rvalid, cfgDone, reqDone, reqForward, cplDone, cplForward;
  logic [NFN-1:0] ptReqValid, ptReqReady, ptCplValid, ntIrq;
  logic [NFN-1:0][31:0] ptReqAddr, ptCplData;
  int n_mismatch = 0, checks = 0, cyc = 0;
  always #10 mclk = ~mclk;
  nti_bridge dut (.*, .ptReqWrite(), .ptReqData());
  nti_pt_partner #(.CPL_DATA(PT_REPLY)) peer (.*);
  // ========
  // Access tasks
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    @(posedge mclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    fork
      @(posedge mclk iff awready) awvalid <= 0;
      @(posedge mclk iff wready) wvalid <= 0;
    join
    @(posedge mclk iff bvalid) bready <= 0;
  endtask
  task automatic rd(input logic [13:0] a);
    @(posedge mclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    @(posedge mclk iff arready) arvalid <= 0;
    @(posedge mclk iff rvalid) rready <= 0;
    v = rdata;
  endtask
  task automatic pulse();
    @(posedge mclk) {reqValid, cplValid, cfgValid} <= 3'b000;
    @(negedge mclk);
  endtask
  task automatic req(input logic [2:0] p, input logic [15:0] id, input logic [1:0] eg);
    @(posedge mclk) {reqPart, reqRequesterId, reqEgressFunc, reqValid} <= {p, id, eg, 1'b1};
    pulse();
  endtask
  task automatic cpl(input logic [15:0] id);
    @(posedge mclk) {cplRequesterId, cplValid} <= {id, 1'b1};
    pulse();
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      end_sim();
    end
  end
  // ========
  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 0;
    rd(14'h0000); chk(v, ID_VALUE);
    rd(14'h3008); chk(v, CLASS_VALUE);
    rd(14'h00FC); chk(rresp, AXI_SLVERR);
    wr(14'h00F8, 32'h0); chk(bresp, AXI_SLVERR);
    wr(14'h0080, 32'h0101);
    wr(14'h1080, 32'h0100);
    wr(14'h0400, 32'h0_0011);
    wr(14'h2404, 32'h2_0101);
    req(3'd0, 16'h0008, 2'd1); chk({reqDone, reqForward, reqNewId}, {2'b11, 16'h0180});
    req(3'd1, 16'h0080, 2'd0); chk({reqDone, reqForward, reqNewId}, {2'b11, 16'h0181});
    req(3'd1, 16'h0008, 2'd1); chk({reqDone, reqForward}, 2'b10);
    cpl(16'h0180); chk({cplForward, cplNewRequesterId, cplNewCompleterId}, {1'b1, 32'h0008_0101});
    cpl(16'h0181); chk({cplDone, cplForward, cplPart}, {2'b11, 3'd1});
    cpl(16'h0140); chk({cplDone, cplForward}, 2'b10);
    @(posedge mclk) {cfgOffset, cfgRequesterId, cfgValid} <= {OFF_CAPID, 16'h0008, 1'b1};
    pulse(); chk({cfgDone, cfgRdData}, {1'b1, 32'h0008});
    wr(14'h0120, 32'h6);
    wr(14'h0100, 32'hCAFE_0001);
    wr(14'h0100, 32'hBEEF_0002);
    @(posedge mclk) chk(ntIrq, 4'b0011);
    rd(14'h1118); chk(v, 32'hCAFE_0001);
    rd(14'h1130); chk(v, 32'h0);
    wr(14'h0130, 32'hF0);
    wr(14'h0200, 32'h2);
    wr(14'h0140, 32'h1);
    @(posedge mclk) chk(ntIrq, 4'b0010);
    rd(14'h1144); chk(v, 32'h1);
    wr(14'h0140, 32'h1);
    wr(14'h1144, 32'h1);
    @(posedge mclk) chk(ntIrq, 4'b0000);
    wr(14'h0150, 32'h1234);
    wr(14'h0158, 32'h1);
    do rd(14'h0158); while (v[0] === 1'b1);
    rd(14'h0154); chk(v, PT_REPLY ^ 32'h1234);
    end_sim();
  end
endmodule
